// file: rtl/spsdp_master.sv
// Controlling end of the serial datagram port: an APB slave with command,
// data, control and status words, and a mode 3 link master that runs one
// 40-bit datagram per start and keeps the received reply.
// Assumes ref_clk is the same clock the device end samples the link with.
`default_nettype none
`timescale 1ns/1ps

module spsdp_master
#(
    parameter int SCK_HALF = spsdp_pkg::SCK_HALF_CYC
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // APB slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial link
    spsdp_link_if.master link
);

    typedef enum logic [2:0] {SPSDP_IDLE, SPSDP_LEAD, SPSDP_LOW, SPSDP_HIGH, SPSDP_TRAIL, SPSDP_GAP} spsdp_state_t;

    localparam logic [7:0] HALF_LAST = 8'(SCK_HALF - 1);
    localparam logic [5:0] LAST_BIT = 6'(spsdp_pkg::DGRAM_W - 1);

    logic [7:0] tx_cmd;
    logic [31:0] tx_data;
    logic [7:0] rx_stat;
    logic [31:0] rx_data;
    logic busy;
    logic done;
    logic access;
    logic commit;
    logic start;
    logic finish;

    ////////////////////////////////////////////////////////////////////////
    // APB: one wait state so that read data and pready come from flops.

    assign access = psel & penable;
    assign commit = access & pready;
    assign start = commit & pwrite & (paddr == spsdp_pkg::REG_CTRL) & pwdata[spsdp_pkg::CTRL_GO_BIT] & ~busy;

    function automatic logic mapped(input logic [7:0] a);
        return a == spsdp_pkg::REG_TX_CMD || a == spsdp_pkg::REG_TX_DATA || a == spsdp_pkg::REG_CTRL
            || a == spsdp_pkg::REG_STATUS || a == spsdp_pkg::REG_RX_STAT || a == spsdp_pkg::REG_RX_DATA;
    endfunction

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pready <= 1'h0;
            pslverr <= 1'h0;
            prdata <= '0;
        end
        else
        begin
            pready <= access & ~pready;
            pslverr <= access & ~pready & ~mapped(paddr);
            prdata <= '0;
            if (access && !pready && !pwrite)
            begin
                case (paddr)
                    spsdp_pkg::REG_TX_CMD: prdata <= {24'h0, tx_cmd};
                    spsdp_pkg::REG_TX_DATA: prdata <= tx_data;
                    spsdp_pkg::REG_STATUS: prdata <= {30'h0, done, busy};
                    spsdp_pkg::REG_RX_STAT: prdata <= {24'h0, rx_stat};
                    spsdp_pkg::REG_RX_DATA: prdata <= rx_data;
                    default: prdata <= '0;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tx_cmd <= '0;
            tx_data <= '0;
        end
        else if (commit && pwrite)
        begin
            if (paddr == spsdp_pkg::REG_TX_CMD)
                tx_cmd <= pwdata[7:0];
            if (paddr == spsdp_pkg::REG_TX_DATA)
                tx_data <= pwdata;
        end
    end

    // A finishing frame wins over a software clear in the same cycle.
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            done <= 1'h0;
        else if (finish)
            done <= 1'h1;
        else if (commit && pwrite && paddr == spsdp_pkg::REG_STATUS && pwdata[spsdp_pkg::STS_DONE_BIT])
            done <= 1'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Link sequencer.

    spsdp_state_t state;
    logic [7:0] timer;
    logic [5:0] bit_idx;
    logic [spsdp_pkg::DGRAM_W-1:0] tx_sr;
    logic [spsdp_pkg::DGRAM_W-1:0] rx_sr;
    logic [1:0] sdo_sync;
    logic [7:0] addr_byte;
    logic half_end;
    logic sck_q;
    logic cs_n_q;
    logic sdi_q;

    // The write flag becomes the top bit by adding the offset to the address.
    assign addr_byte = {1'h0, tx_cmd[spsdp_pkg::ADDR_W-1:0]}
                     + (tx_cmd[spsdp_pkg::TX_CMD_WRITE_BIT] ? spsdp_pkg::WRITE_OFFSET : 8'h00); // R3 R2
    assign half_end = (timer == HALF_LAST);
    assign finish = (state == SPSDP_GAP) & half_end;

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            sdo_sync <= 2'h0;
        else
            sdo_sync <= {sdo_sync[0], link.sdo};
    end

    // Half periods of several ref_clk cycles keep the link well under half
    // the system clock, which the device's resynchroniser needs.
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            timer <= '0;
        else if (state == SPSDP_IDLE || half_end)
            timer <= '0;
        else
            timer <= timer + 8'h1; // R18 R19
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= SPSDP_IDLE;
            sck_q <= 1'h1;
            cs_n_q <= 1'h1;
            sdi_q <= 1'h0;
            busy <= 1'h0;
            bit_idx <= '0;
            tx_sr <= '0;
            rx_sr <= '0;
            rx_stat <= '0;
            rx_data <= '0;
        end
        else
        begin
            case (state)
                SPSDP_IDLE:
                    if (start)
                    begin
                        tx_sr <= {addr_byte, tx_data}; // R1
                        sdi_q <= addr_byte[7];
                        cs_n_q <= 1'h0;
                        busy <= 1'h1;
                        bit_idx <= '0;
                        state <= SPSDP_LEAD;
                    end
                SPSDP_LEAD:
                    if (half_end)
                    begin
                        sck_q <= 1'h0; // R20
                        state <= SPSDP_LOW;
                    end
                SPSDP_LOW:
                    if (half_end)
                    begin
                        sck_q <= 1'h1; // R20
                        state <= SPSDP_HIGH;
                    end
                SPSDP_HIGH:
                    if (half_end)
                    begin
                        rx_sr <= {rx_sr[spsdp_pkg::DGRAM_W-2:0], sdo_sync[1]};
                        tx_sr <= {tx_sr[spsdp_pkg::DGRAM_W-2:0], 1'h0};
                        bit_idx <= bit_idx + 6'h1;
                        if (bit_idx == LAST_BIT)
                            state <= SPSDP_TRAIL; // R15
                        else
                        begin
                            sck_q <= 1'h0;
                            sdi_q <= tx_sr[spsdp_pkg::DGRAM_W-2]; // R20
                            state <= SPSDP_LOW;
                        end
                    end
                SPSDP_TRAIL:
                    if (half_end)
                    begin
                        cs_n_q <= 1'h1; // R15
                        state <= SPSDP_GAP;
                    end
                SPSDP_GAP:
                    if (half_end)
                    begin
                        rx_stat <= rx_sr[spsdp_pkg::DGRAM_W-1:spsdp_pkg::DATA_W];
                        rx_data <= rx_sr[spsdp_pkg::DATA_W-1:0];
                        busy <= 1'h0;
                        state <= SPSDP_IDLE;
                    end
                default:
                    state <= SPSDP_IDLE;
            endcase
        end
    end

    assign link.sck = sck_q;
    assign link.cs_n = cs_n_q;
    assign link.sdi = sdi_q;

endmodule

`default_nettype wire

// file: rtl/spsdp_pkg.sv
// Shared constants for the serial datagram port: frame layout, status byte
// layout, link timing and the register map of the controlling end.
// Assumes both ends run from the same 10 MHz reference clock.
`default_nettype none

package spsdp_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Datagram layout.
    localparam int DGRAM_W = 40;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 7;
    localparam int STAT_W = 8;
    localparam int RW_BIT = 39;
    localparam int ADDR_HI = 38;
    localparam int ADDR_LO = 32;
    localparam logic [7:0] WRITE_OFFSET = 8'h80;

    ////////////////////////////////////////////////////////////////////////
    // Status byte positions and their sources.
    localparam int ST_RSVD = 7;
    localparam int ST_STOP_TWO = 6;
    localparam int ST_STOP_ONE = 5;
    localparam int ST_VREACH_TWO = 4;
    localparam int ST_VREACH_ONE = 3;
    localparam int ST_DRV_TWO = 2;
    localparam int ST_DRV_ONE = 1;
    localparam int ST_RESET = 0;
    localparam int RAMP_STOP_LEFT_BIT = 0;
    localparam int RAMP_VREACH_BIT = 8;
    localparam int GC_DRV_TWO = 2;
    localparam int GC_DRV_ONE = 1;
    localparam int GC_RESET = 0;
    localparam int GC_W = 3;

    ////////////////////////////////////////////////////////////////////////
    // Timing.
    localparam int SYS_PERIOD_NS = 100;
    localparam int SCK_PERIOD_NS = 800;
    localparam int OSC_MARGIN_PCT = 10;
    localparam int SCK_HALF_CYC = SCK_PERIOD_NS / (2 * SYS_PERIOD_NS);

    ////////////////////////////////////////////////////////////////////////
    // Register map of the controlling end, one 32-bit word each.
    localparam logic [7:0] REG_TX_CMD = 8'h00;
    localparam logic [7:0] REG_TX_DATA = 8'h04;
    localparam logic [7:0] REG_CTRL = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_RX_STAT = 8'h10;
    localparam logic [7:0] REG_RX_DATA = 8'h14;
    localparam int TX_CMD_WRITE_BIT = 7;
    localparam int CTRL_GO_BIT = 0;
    localparam int STS_BUSY_BIT = 0;
    localparam int STS_DONE_BIT = 1;

endpackage

`default_nettype wire

// file: rtl/spsdp_link_if.sv
// Four-wire serial link between the controlling end and the device end.
// Assumes mode 3 signalling with an active-low chip select.
`default_nettype none
`timescale 1ns/1ps

interface spsdp_link_if;
    logic sck;
    logic cs_n;
    logic sdi;
    logic sdo;

    modport device(input sck, input cs_n, input sdi, output sdo);
    modport master(output sck, output cs_n, output sdi, input sdo);
endinterface

`default_nettype wire

// file: rtl/spsdp_device.sv
// Device end of the serial datagram port: 40-bit shift register, command
// latch, pipelined read reply and status byte capture.
// Assumes the register set answers a read strobe with data in the same cycle
// and that the link arrives asynchronously to ref_clk.
//
// Operation
// R1: Datagram is address byte plus four data bytes.
// R2: Bit 39 zero reads, one writes.
// R3: Master adds 0x80 to address for writes.
// R4: Reply always shifted; carries previous read data.
// R5: After a write, reply echoes written data.
// R6: Read datagram data is dummy; register untouched.
// R7: Status byte occupies reply bits 39 to 32.
// R8: Status captured at access end, sent next.
// R9: Bit 7 zero; bits 6,5 left stop flags.
// R10: Bits 4,3 mirror velocity reached flags.
// R11: Bits 2,1 mirror driver faults, cleared externally.
// R12: Bit 0 mirrors reset flag until read.
// R13: Data right aligned, two's complement, packed fields.
// R14: Sample rising, drive after falling, MSB first.
// R15: Master gives at least 40 clocks, select low.
// R16: Extra bits reappear on output after 40 clocks.
// R17: Select rising latches last 40 bits as command.
// R18: Port on system clock; link at most half.
// R19: Internal oscillator needs further 10% link margin.
// R20: Mode 3: idle high, drive falling, sample rising.
// R21: Link inputs resynchronised before edge detection.
`default_nettype none
`timescale 1ns/1ps

module spsdp_device
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Serial link
    spsdp_link_if.device link,
    // Register set
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic [spsdp_pkg::ADDR_W-1:0] reg_addr,
    output logic [spsdp_pkg::DATA_W-1:0] reg_wdata,
    input wire logic [spsdp_pkg::DATA_W-1:0] reg_rdata,
    // Status sources
    input wire logic [spsdp_pkg::DATA_W-1:0] motion_profile_state_one,
    input wire logic [spsdp_pkg::DATA_W-1:0] motion_profile_state_two,
    input wire logic [spsdp_pkg::GC_W-1:0] global_condition_register,
    // Link observation
    output logic cmd_dropped
);

    ////////////////////////////////////////////////////////////////////////
    // Resynchronisers. Idle level of select and clock is high.

    logic [1:0] sck_sync;
    logic [1:0] cs_sync;
    logic [1:0] sdi_sync;
    logic sck_prev;
    logic cs_prev;

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sck_sync <= 2'h3;
            cs_sync <= 2'h3;
            sdi_sync <= 2'h0;
        end
        else
        begin
            sck_sync <= {sck_sync[0], link.sck}; // R21 R18
            cs_sync <= {cs_sync[0], link.cs_n}; // R21
            sdi_sync <= {sdi_sync[0], link.sdi}; // R21
        end
    end

    // Edges are found on the second stage only, so a metastable first stage
    // never reaches a decision.
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sck_prev <= 1'h1;
            cs_prev <= 1'h1;
        end
        else
        begin
            sck_prev <= sck_sync[1];
            cs_prev <= cs_sync[1];
        end
    end

    logic selected;
    logic sck_rise;
    logic sck_fall;
    logic cs_fall;
    logic cs_rise;

    assign selected = ~cs_sync[1];
    assign sck_rise = selected & sck_sync[1] & ~sck_prev; // R20 R21
    assign sck_fall = selected & ~sck_sync[1] & sck_prev; // R20 R21
    assign cs_fall = ~cs_sync[1] & cs_prev;
    assign cs_rise = cs_sync[1] & ~cs_prev;

    ////////////////////////////////////////////////////////////////////////
    // Reply word and status byte kept between datagrams.

    logic [spsdp_pkg::DATA_W-1:0] reply;
    logic [spsdp_pkg::STAT_W-1:0] status;
    logic [spsdp_pkg::DGRAM_W-1:0] shifter;
    logic [5:0] bit_count;
    logic read_pending;
    logic cmd_ok;

    localparam logic [5:0] FULL_COUNT = 6'(spsdp_pkg::DGRAM_W);

    // Fewer than a full datagram of clocks leaves only garbage in the
    // shifter, so such a frame is not acted on.
    assign cmd_ok = cs_rise & (bit_count == FULL_COUNT); // R15 R17

    function automatic logic [spsdp_pkg::STAT_W-1:0] status_byte(
        input logic [spsdp_pkg::DATA_W-1:0] ramp_one,
        input logic [spsdp_pkg::DATA_W-1:0] ramp_two,
        input logic [spsdp_pkg::GC_W-1:0] gc
    );
        logic [spsdp_pkg::STAT_W-1:0] s;
        s = '0;
        s[spsdp_pkg::ST_RSVD] = 1'h0; // R9
        s[spsdp_pkg::ST_STOP_TWO] = ramp_two[spsdp_pkg::RAMP_STOP_LEFT_BIT]; // R9
        s[spsdp_pkg::ST_STOP_ONE] = ramp_one[spsdp_pkg::RAMP_STOP_LEFT_BIT]; // R9
        s[spsdp_pkg::ST_VREACH_TWO] = ramp_two[spsdp_pkg::RAMP_VREACH_BIT]; // R10
        s[spsdp_pkg::ST_VREACH_ONE] = ramp_one[spsdp_pkg::RAMP_VREACH_BIT]; // R10
        s[spsdp_pkg::ST_DRV_TWO] = gc[spsdp_pkg::GC_DRV_TWO]; // R11
        s[spsdp_pkg::ST_DRV_ONE] = gc[spsdp_pkg::GC_DRV_ONE]; // R11
        s[spsdp_pkg::ST_RESET] = gc[spsdp_pkg::GC_RESET]; // R12
        return s;
    endfunction

    // The flags are sampled at the end of every frame, even a short one, so
    // the next reply never shows a status older than the last access.
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            status <= '0;
        else if (cs_rise)
            status <= status_byte(motion_profile_state_one, motion_profile_state_two,
                                  global_condition_register); // R8
    end

    ////////////////////////////////////////////////////////////////////////
    // Shift register. It is a plain 40-bit delay line while selected, so any
    // clocks past the fortieth push received bits straight out again.

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            shifter <= '0;
        else if (cs_fall)
            shifter <= {status, reply}; // R4 R7
        else if (sck_rise)
            shifter <= {shifter[spsdp_pkg::DGRAM_W-2:0], sdi_sync[1]}; // R14 R16
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            bit_count <= '0;
        else if (cs_fall)
            bit_count <= '0;
        else if (sck_rise && bit_count != FULL_COUNT)
            bit_count <= bit_count + 6'h1; // R15
    end

    logic sdo_q;

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            sdo_q <= 1'h0;
        else if (cs_fall)
            sdo_q <= status[spsdp_pkg::STAT_W-1]; // R14
        else if (sck_fall)
            sdo_q <= shifter[spsdp_pkg::DGRAM_W-1]; // R14 R16
    end

    assign link.sdo = sdo_q;

    ////////////////////////////////////////////////////////////////////////
    // Command latch and register access.

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            reg_wr_en <= 1'h0;
            reg_rd_en <= 1'h0;
            reg_addr <= '0;
            reg_wdata <= '0;
        end
        else
        begin
            reg_wr_en <= cmd_ok & shifter[spsdp_pkg::RW_BIT]; // R2 R17
            reg_rd_en <= cmd_ok & ~shifter[spsdp_pkg::RW_BIT]; // R2 R6
            if (cmd_ok)
                reg_addr <= shifter[spsdp_pkg::ADDR_HI:spsdp_pkg::ADDR_LO]; // R1
            if (cmd_ok && shifter[spsdp_pkg::RW_BIT])
                reg_wdata <= shifter[spsdp_pkg::DATA_W-1:0]; // R1 R13
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            read_pending <= 1'h0;
        else
            read_pending <= cmd_ok & ~shifter[spsdp_pkg::RW_BIT];
    end

    // A write echoes its own data; a read fetches the addressed register one
    // cycle later. Both are ready long before the next select can fall.
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            reply <= '0;
        else if (cmd_ok && shifter[spsdp_pkg::RW_BIT])
            reply <= shifter[spsdp_pkg::DATA_W-1:0]; // R5
        else if (read_pending)
            reply <= reg_rdata; // R4 R13
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            cmd_dropped <= 1'h0;
        else
            cmd_dropped <= cs_rise & (bit_count != FULL_COUNT);
    end

endmodule

`default_nettype wire

// file: bench/spsdp_link_assertions.sv
// Checker for the serial link between the two ends of the datagram port.
// Assumes a link that idles with sck and cs_n high and the default divider.
`timescale 1ns/1ps
`default_nettype none

module spsdp_link_assertions
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Link
    input wire logic sck,
    input wire logic cs_n,
    input wire logic sdi,
    input wire logic sdo
);
    logic sck_q;
    logic [5:0] rise_cnt;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            sck_q <= 1'b1;
        else
            sck_q <= sck;
    end

    // Counts rising serial clocks in a frame; it still holds the total when cs_n rise is sampled.
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            rise_cnt <= 6'h00;
        else if (cs_n)
            rise_cnt <= 6'h00;
        else if (sck && !sck_q)
            rise_cnt <= rise_cnt + 6'h01;
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    sequence frame_end_s;
        $rose(cs_n);
    endsequence
    sequence first_rise_s;
        $rose(sck) && !cs_n && rise_cnt == 6'h00;
    endsequence

    idle_clock_high_a: assert property (cs_n |-> sck)
        else $error("serial clock low while deselected");
    select_edge_sck_a: assert property (($fell(cs_n) || $rose(cs_n)) |-> sck && $past(sck))
        else $error("chip select moved while serial clock low");
    forty_clocks_a: assert property (frame_end_s |-> rise_cnt == 6'h28)
        else $error("frame did not carry forty clocks");
    clock_half_a: assert property ($changed(sck) |=> $stable(sck))
        else $error("serial clock level shorter than two cycles");
    select_gap_a: assert property (frame_end_s |=> cs_n [*3])
        else $error("chip select high time too short");
    sdi_hold_a: assert property (!cs_n && $past(!cs_n) && sck && $past(sck) |-> $stable(sdi))
        else $error("serial input moved while clock high");
    sdo_hold_a: assert property (!cs_n && sck && $past(sck) && rise_cnt != 6'h00 |-> $stable(sdo))
        else $error("serial output moved while clock high");
    status_top_zero_a: assert property (first_rise_s |-> !sdo)
        else $error("reserved status bit not zero");

    frame_seen_c: cover property (frame_end_s);
endmodule

`default_nettype wire

// file: bench/tb_top.sv
// Bench: both ends on one link, plus a second device end on a bench-driven link.
// Assumes the default link divider of the controlling end (four cycles a half).
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, wr_en, rd_en, wr_b, drop_b;
    logic [6:0] addr, addr_b;
    logic [31:0] wdata, wdata_b;
    logic [31:0] ramp1 = 32'h0, ramp2 = 32'h0;
    logic [2:0] gc = 3'h0;
    logic [31:0] regs [128];
    logic [31:0] exp_mem [128];
    logic [39:0] exp_r = 40'h0;
    logic [38:0] got_b = 39'h0;
    logic sck_b = 1'b1, cs_b = 1'b1, sdi_b = 1'b0;
    int fail_count = 0, cmp_count = 0, cyc = 0, wr_seen = 0, drop_seen = 0;

    ////////////////////////////////////////////////////////////////////////
    spsdp_link_if link_a();
    spsdp_link_if link_b();
    assign link_b.sck = sck_b;
    assign link_b.cs_n = cs_b;
    assign link_b.sdi = sdi_b;

    spsdp_master spsdp_master_inst (.ref_clk(ref_clk), .arst_n(arst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link_a.master));
    spsdp_device spsdp_device_inst (.ref_clk(ref_clk), .arst_n(arst_n), .link(link_a.device),
        .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata),
        .reg_rdata(rd_en ? regs[addr] : 32'h0),
        .motion_profile_state_one(ramp1), .motion_profile_state_two(ramp2),
        .global_condition_register(gc), .cmd_dropped());
    spsdp_device spsdp_device_inst_b (.ref_clk(ref_clk), .arst_n(arst_n), .link(link_b.device),
        .reg_wr_en(wr_b), .reg_rd_en(), .reg_addr(addr_b), .reg_wdata(wdata_b), .reg_rdata(32'h0),
        .motion_profile_state_one(32'h0), .motion_profile_state_two(32'h0),
        .global_condition_register(3'h0), .cmd_dropped(drop_b));
    spsdp_link_assertions spsdp_link_assertions_inst (.ref_clk(ref_clk), .arst_n(arst_n),
        .sck(link_a.sck), .cs_n(link_a.cs_n), .sdi(link_a.sdi), .sdo(link_a.sdo));

    ////////////////////////////////////////////////////////////////////////
    always #50 ref_clk = ~ref_clk;

    // Register set behind the device: read data stands only while the read strobe does.
    always @(posedge ref_clk)
    begin
        if (wr_en)
            regs[addr] <= wdata;
        if (wr_b)
            got_b <= {addr_b, wdata_b};
        wr_seen <= wr_seen + int'(wr_b);
        drop_seen <= drop_seen + int'(drop_b);
    end

    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            $display("MISMATCH at %0t: run timed out", $time);
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] stat_of(input logic [31:0] a, input logic [31:0] b, input logic [2:0] g);
        return {1'b0, b[0], a[0], b[8], a[8], g};
    endfunction

    task automatic check(input logic [39:0] got, input logic [39:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // One APB transfer; read data and error are taken at the edge where pready is sampled high.
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r,
        output logic e);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do
            @(posedge ref_clk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic dgram(input logic [39:0] tx);
        logic [31:0] r, st;
        logic e;
        apb(spsdp_pkg::REG_TX_CMD, 1'b1, {24'h0, tx[39:32]}, r, e);
        apb(spsdp_pkg::REG_TX_DATA, 1'b1, tx[31:0], r, e);
        apb(spsdp_pkg::REG_CTRL, 1'b1, 32'h1, r, e);
        do
            apb(spsdp_pkg::REG_STATUS, 1'b0, 32'h0, st, e);
        while (st[spsdp_pkg::STS_DONE_BIT] !== 1'b1);
        apb(spsdp_pkg::REG_STATUS, 1'b1, 32'h2, r, e);
        apb(spsdp_pkg::REG_RX_STAT, 1'b0, 32'h0, st, e);
        apb(spsdp_pkg::REG_RX_DATA, 1'b0, 32'h0, r, e);
        check({st[7:0], r}, exp_r, "reply");
        exp_r = {stat_of(ramp1, ramp2, gc), tx[39] ? tx[31:0] : exp_mem[tx[38:32]]};
        if (tx[39])
            exp_mem[tx[38:32]] = tx[31:0];
        ramp1 <= $urandom();
        ramp2 <= $urandom();
        gc <= 3'($urandom());
    endtask

    // Bench-driven frame of n bits, MSB first; bits past forty must echo what went in forty clocks before.
    task automatic drive_b(input int n, input logic [47:0] b);
        cs_b <= 1'b0;
        sdi_b <= b[n-1];
        repeat (4) @(posedge ref_clk);
        for (int i = 0; i < n; i++)
        begin
            sck_b <= 1'b0;
            if (i > 0)
                sdi_b <= b[n-1-i];
            repeat (3) @(posedge ref_clk);
            @(negedge ref_clk);
            if (i >= 40)
                check({39'h0, link_b.sdo}, {39'h0, b[n-1-i+40]}, "chained bit");
            @(posedge ref_clk);
            sck_b <= 1'b1;
            repeat (4) @(posedge ref_clk);
        end
        cs_b <= 1'b1;
        sdi_b <= ~sdi_b;
        repeat (12) @(posedge ref_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [31:0] r;
        logic e;
        void'($urandom(69));
        for (int i = 0; i < 128; i++)
        begin
            regs[i] = 32'h0;
            exp_mem[i] = 32'h0;
        end
        repeat (12) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        check({37'h0, link_a.sck, link_a.cs_n, link_b.sdo}, 40'h06, "idle link");
        $display("test reset done");
        dgram({1'b1, 7'h7F, 32'hFFFFFFFF});
        dgram({1'b0, 7'h7F, 32'hFFFFFFFF});
        dgram({1'b0, 7'h7F, 32'h00000000});
        dgram({1'b1, 7'h00, 32'h80000000});
        dgram({1'b0, 7'h00, 32'h12345678});
        $display("test corner datagrams done");
        repeat (14)
            dgram({1'($urandom()), 7'($urandom_range(3)), 32'($urandom())});
        $display("test random datagrams done");
        apb(8'h3C, 1'b0, 32'h0, r, e);
        check({7'h0, e, r}, 40'h0100000000, "unmapped access");
        $display("test unmapped access done");
        drive_b(48, {8'($urandom()), 1'b1, 7'h15, 32'hC0FFEE01});
        check({32'h0, 8'(wr_seen)}, 40'h01, "chained write count");
        check({1'b0, got_b}, {1'b0, 7'h15, 32'hC0FFEE01}, "chained command");
        drive_b(20, 48'($urandom()));
        check({24'h0, 8'(drop_seen), 8'(wr_seen)}, 40'h0101, "short frame");
        $display("test bench-driven frames done");
        wrap_up();
    end
endmodule

`default_nettype wire
